// File: verilog/port_pin_io.sv
`timescale 1ns/10ps

// What this block does
// - Analog select routes pad, blocks digital input
// - Analog select overrides every input enable
// - Direction zero: input data is pad level
// - Pull-up follows its option bit only
// - Open-drain: driver only pulls low
// - Direction one: push-pull drives output latch
// - Secondary enable keeps input path open
// - Otherwise input opens only during read strobe
// - Port read: latch if output, else pad
// - Pad-data register always returns pad level
// - Pull-up register resets to zero
// - Direction register resets to zero
module port_pin_io #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic [WIDTH-1:0] secondary_input_en,
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe,
  output logic      [WIDTH-1:0] pad_pullup_en,
  output logic      [WIDTH-1:0] pad_input_gate_en,
  output logic      [WIDTH-1:0] analog_path_en,
  output logic      [WIDTH-1:0] digital_in
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] port_output_latch_r;
  logic [WIDTH-1:0] port_pullup_enable_r;
  logic [WIDTH-1:0] port_direction_r;
  logic [WIDTH-1:0] port_debounce_enable_r;
  logic [WIDTH-1:0] port_pin_change_enable_r;
  logic [WIDTH-1:0] port_open_drain_r;
  logic [WIDTH-1:0] analog_select_r;
  logic [WIDTH-1:0] analog_capable;
  logic             cpu_read_strobe_n;
  logic [WIDTH-1:0] read_path_en;
  logic [7:0]       reg_rdata_nxt;

  // Only the two analog pins hold an analog select bit
  always_comb
  begin
    analog_capable = '0;
    analog_capable[port_pin_pkg::ANALOG_PIN_SIX]   = 1'b1;
    analog_capable[port_pin_pkg::ANALOG_PIN_SEVEN] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      port_output_latch_r <= WIDTH'(port_pin_pkg::RST_PORT_REG);
    else if (reg_wr && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH)
      port_output_latch_r <= reg_wdata[WIDTH-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      port_pullup_enable_r <= WIDTH'(port_pin_pkg::RST_PORT_REG);
    else if (reg_wr && reg_addr == port_pin_pkg::ADDR_PULLUP_ENABLE)
      port_pullup_enable_r <= reg_wdata[WIDTH-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      port_direction_r <= WIDTH'(port_pin_pkg::RST_PORT_REG);
    else if (reg_wr && reg_addr == port_pin_pkg::ADDR_DIRECTION)
      port_direction_r <= reg_wdata[WIDTH-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      port_debounce_enable_r   <= WIDTH'(port_pin_pkg::RST_PORT_REG);
      port_pin_change_enable_r <= WIDTH'(port_pin_pkg::RST_PORT_REG);
      port_open_drain_r        <= WIDTH'(port_pin_pkg::RST_PORT_REG);
      analog_select_r          <= WIDTH'(port_pin_pkg::RST_PORT_REG);
    end
    else if (reg_wr)
    begin
      if (reg_addr == port_pin_pkg::ADDR_DEBOUNCE_EN)
        port_debounce_enable_r <= reg_wdata[WIDTH-1:0];
      if (reg_addr == port_pin_pkg::ADDR_PIN_CHANGE_EN)
        port_pin_change_enable_r <= reg_wdata[WIDTH-1:0];
      if (reg_addr == port_pin_pkg::ADDR_OPEN_DRAIN)
        port_open_drain_r <= reg_wdata[WIDTH-1:0];
      if (reg_addr == port_pin_pkg::ADDR_ANALOG_SELECT)
        analog_select_r <= reg_wdata[WIDTH-1:0] & analog_capable;
    end
  end

  // ---------------------------------------------------------------
  // Pad control per pin
  // ---------------------------------------------------------------
  // Active-low strobe that opens the input gate during a port read
  assign cpu_read_strobe_n = ~(reg_rd && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      assign analog_path_en[i] = analog_select_r[i];
      // Analog select has the highest priority on the input gate
      assign pad_input_gate_en[i] = ~analog_select_r[i] &
                                    (secondary_input_en[i] | ~cpu_read_strobe_n);
      assign read_path_en[i] = ~analog_select_r[i] & ~cpu_read_strobe_n;
      assign digital_in[i]   = pad_input_gate_en[i] & pad_in[i];
      assign pad_pullup_en[i] = port_pullup_enable_r[i];
      // Open drain drives only the low level
      assign pad_out[i] = port_open_drain_r[i] ? 1'b0 : port_output_latch_r[i];
      assign pad_oe[i]  = port_direction_r[i] &
                          (~port_open_drain_r[i] | ~port_output_latch_r[i]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    reg_rdata_nxt = port_pin_pkg::READ_UNMAPPED;
    unique case (reg_addr)
      port_pin_pkg::ADDR_OUTPUT_LATCH:
        reg_rdata_nxt[WIDTH-1:0] = (port_direction_r & port_output_latch_r) |
                                   (~port_direction_r & read_path_en & pad_in);
      port_pin_pkg::ADDR_PULLUP_ENABLE:  reg_rdata_nxt[WIDTH-1:0] = port_pullup_enable_r;
      port_pin_pkg::ADDR_DIRECTION:      reg_rdata_nxt[WIDTH-1:0] = port_direction_r;
      port_pin_pkg::ADDR_DEBOUNCE_EN:    reg_rdata_nxt[WIDTH-1:0] = port_debounce_enable_r;
      port_pin_pkg::ADDR_PIN_CHANGE_EN:  reg_rdata_nxt[WIDTH-1:0] = port_pin_change_enable_r;
      port_pin_pkg::ADDR_OPEN_DRAIN:     reg_rdata_nxt[WIDTH-1:0] = port_open_drain_r;
      port_pin_pkg::ADDR_PAD_DATA:       reg_rdata_nxt[WIDTH-1:0] = pad_in;
      port_pin_pkg::ADDR_ANALOG_SELECT:  reg_rdata_nxt[WIDTH-1:0] = analog_select_r;
      default:                           reg_rdata_nxt = port_pin_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= port_pin_pkg::READ_UNMAPPED;
    else if (reg_rd)
      reg_rdata <= reg_rdata_nxt;
    else
      reg_rdata <= port_pin_pkg::READ_UNMAPPED;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_analog_blocks_gate: assert property (@(posedge core_clk) disable iff (rst)
    (analog_select_r != '0) |-> ((pad_input_gate_en & analog_select_r) == '0))
    else $error("input gate open on analog pin");

  a_analog_path_on: assert property (@(posedge core_clk) disable iff (rst)
    analog_path_en == analog_select_r)
    else $error("analog path not following select");

  a_input_pad_level: assert property (@(posedge core_clk) disable iff (rst)
    (digital_in & pad_input_gate_en) == (pad_in & pad_input_gate_en))
    else $error("input data differs from pad");

  a_pullup_follows: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == port_pin_pkg::ADDR_PULLUP_ENABLE |=> pad_pullup_en == $past(reg_wdata[WIDTH-1:0]))
    else $error("pull-up not following its register");

  a_open_drain_low: assert property (@(posedge core_clk) disable iff (rst)
    ((pad_oe & port_open_drain_r & pad_out) == '0))
    else $error("open drain drove high");

  a_push_pull_out: assert property (@(posedge core_clk) disable iff (rst)
    ((port_direction_r & ~port_open_drain_r) & ~pad_oe) == '0 &&
    ((port_direction_r & ~port_open_drain_r) & (pad_out ^ port_output_latch_r)) == '0)
    else $error("push-pull output wrong");

  a_secondary_gate: assert property (@(posedge core_clk) disable iff (rst)
    ((secondary_input_en & ~analog_select_r) & ~pad_input_gate_en) == '0)
    else $error("secondary pin input gate closed");

  a_gate_only_read: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |-> (pad_input_gate_en & ~secondary_input_en) == '0)
    else $error("input gate open outside read");

  a_port_read_data: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH && analog_select_r == '0 |=>
    reg_rdata[WIDTH-1:0] == (($past(port_direction_r) & $past(port_output_latch_r)) |
                             (~$past(port_direction_r) & $past(pad_in))))
    else $error("port read data wrong");

  a_pad_data_read: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == port_pin_pkg::ADDR_PAD_DATA |=> reg_rdata[WIDTH-1:0] == $past(pad_in))
    else $error("pad data read wrong");

  a_reset_zero: assert property (@(posedge core_clk)
    rst |=> port_pullup_enable_r == '0 && port_direction_r == '0)
    else $error("pull-up or direction not zero after reset");

  a_latch_holds: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH) |=> $stable(port_output_latch_r))
    else $error("output latch changed without write");

  // ---------------------------------------------------------------
  // Register updates, pad drive, input gate and read data
  // ---------------------------------------------------------------
  a_latch_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH |=>
    port_output_latch_r == $past(reg_wdata[WIDTH-1:0]))
    else $error("output latch missed a write");

  a_dir_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == port_pin_pkg::ADDR_DIRECTION |=>
    port_direction_r == $past(reg_wdata[WIDTH-1:0]))
    else $error("direction register missed a write");

  a_dir_holds: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr && reg_addr == port_pin_pkg::ADDR_DIRECTION) |=> $stable(port_direction_r))
    else $error("direction changed without write");

  a_od_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == port_pin_pkg::ADDR_OPEN_DRAIN |=>
    port_open_drain_r == $past(reg_wdata[WIDTH-1:0]))
    else $error("open-drain register missed a write");

  a_analog_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == port_pin_pkg::ADDR_ANALOG_SELECT |=>
    analog_select_r == ($past(reg_wdata[WIDTH-1:0]) & analog_capable))
    else $error("analog select missed a write");

  a_analog_holds: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr && reg_addr == port_pin_pkg::ADDR_ANALOG_SELECT) |=> $stable(analog_select_r))
    else $error("analog select changed without write");

  a_analog_pins_only: assert property (@(posedge core_clk) disable iff (rst)
    (analog_select_r & ~analog_capable) == '0)
    else $error("analog select on a digital-only pin");

  a_analog_no_digital: assert property (@(posedge core_clk) disable iff (rst)
    (digital_in & analog_select_r) == '0)
    else $error("digital input passed on analog pin");

  a_analog_no_read: assert property (@(posedge core_clk) disable iff (rst)
    (read_path_en & analog_select_r) == '0)
    else $error("read path open on analog pin");

  a_analog_read_zero: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH |=>
    (reg_rdata[WIDTH-1:0] & ~$past(port_direction_r) & $past(analog_select_r)) == '0)
    else $error("port read saw an analog input pin");

  a_input_not_driven: assert property (@(posedge core_clk) disable iff (rst)
    (~port_direction_r & pad_oe) == '0)
    else $error("input pin driven");

  a_pullup_holds: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr && reg_addr == port_pin_pkg::ADDR_PULLUP_ENABLE) |=> $stable(pad_pullup_en))
    else $error("pull-up changed without its register");

  a_od_released: assert property (@(posedge core_clk) disable iff (rst)
    (port_open_drain_r & port_output_latch_r & pad_oe) == '0)
    else $error("open drain did not release high level");

  a_od_pulls_low: assert property (@(posedge core_clk) disable iff (rst)
    (port_direction_r & port_open_drain_r & ~port_output_latch_r & ~pad_oe) == '0)
    else $error("open drain did not pull low");

  a_od_out_low: assert property (@(posedge core_clk) disable iff (rst)
    (port_open_drain_r & pad_out) == '0)
    else $error("open drain drive value high");

  a_read_opens_gate: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH |-> (pad_input_gate_en | analog_select_r) == '1)
    else $error("input gate shut during port read");

  a_other_read_shut: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr != port_pin_pkg::ADDR_OUTPUT_LATCH |-> (pad_input_gate_en & ~secondary_input_en) == '0)
    else $error("input gate open on other read");

  a_digital_gated: assert property (@(posedge core_clk) disable iff (rst)
    (digital_in & ~pad_input_gate_en) == '0)
    else $error("digital input passed a shut gate");

  a_secondary_digital: assert property (@(posedge core_clk) disable iff (rst)
    (secondary_input_en & ~analog_select_r & (digital_in ^ pad_in)) == '0)
    else $error("secondary pin input differs from pad");

  a_port_read_out: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == port_pin_pkg::ADDR_OUTPUT_LATCH |=>
    (reg_rdata[WIDTH-1:0] & $past(port_direction_r)) == ($past(port_output_latch_r) & $past(port_direction_r)))
    else $error("port read of output pin not latch");

  a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == port_pin_pkg::READ_UNMAPPED)
    else $error("read data outside read cycle");

  a_reset_outputs: assert property (@(posedge core_clk)
    rst |=> pad_oe == '0 && port_output_latch_r == '0 &&
    reg_rdata == port_pin_pkg::READ_UNMAPPED)
    else $error("outputs not idle after reset");

endmodule

// File: verilog/port_pin_pkg.sv
package port_pin_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_OUTPUT_LATCH   = 8'h80;
  localparam logic [7:0] ADDR_PULLUP_ENABLE  = 8'h89;
  localparam logic [7:0] ADDR_DIRECTION      = 8'h98;
  localparam logic [7:0] ADDR_DEBOUNCE_EN    = 8'hC0;
  localparam logic [7:0] ADDR_PIN_CHANGE_EN  = 8'hC1;
  localparam logic [7:0] ADDR_OPEN_DRAIN     = 8'hC2;
  localparam logic [7:0] ADDR_PAD_DATA       = 8'hC3;
  localparam logic [7:0] ADDR_ANALOG_SELECT  = 8'hC4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT_REG        = 8'h00;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // Pins that can be routed to an analog channel
  localparam int         ANALOG_PIN_SIX      = 6;
  localparam int         ANALOG_PIN_SEVEN    = 7;

endpackage

// File: verification/pad_model.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// External circuitry on the port pads
// ---------------------------------------------------------------
module pad_model #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic [WIDTH-1:0] pad_out,
  input  wire logic [WIDTH-1:0] pad_oe,
  input  wire logic [WIDTH-1:0] pad_pullup_en,
  input  wire logic [WIDTH-1:0] ext_en,
  input  wire logic [WIDTH-1:0] ext_val,
  output logic      [WIDTH-1:0] pad_level
);
  logic [WIDTH-1:0] float_r = {WIDTH{1'b0}};

  // A released line with no pull-up and no external driver wanders every cycle
  always @(posedge core_clk)
    float_r <= ~float_r;

  assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                   | (~pad_oe & ~ext_en & (pad_pullup_en | float_r));
endmodule

// File: verification/port_pin_io_cell_logic_tb.sv
`timescale 1ns/10ps

`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end

module port_pin_io_cell_logic_tb;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr   = 1'b0;
  logic       reg_rd   = 1'b0;
  logic [7:0] reg_rdata, pad_in, pad_out, pad_oe, pad_pullup_en, pad_input_gate_en, analog_path_en, digital_in;
  logic [7:0] sec_en   = 8'h00;
  logic [7:0] ext_en   = 8'hFF;
  logic [7:0] ext_val  = 8'h3C;
  logic [7:0] gate_snap;
  int         n_fail = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [7:0] reset_addrs [8] = '{8'h80, 8'h89, 8'h98, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'h81};

  initial forever #2 core_clk = ~core_clk;

  port_pin_io dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .secondary_input_en(sec_en),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .pad_input_gate_en(pad_input_gate_en), .analog_path_en(analog_path_en), .digital_in(digital_in));

  pad_model pad_u (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_in));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    #1 gate_snap = pad_input_gate_en;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_fail++;
      test_done;
    end
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    foreach (reset_addrs[i]) rd(reset_addrs[i], (reset_addrs[i] == 8'h80) ? 8'h3C : 8'h00);
    `CHK("pad_oe", 8'h00, pad_oe)
    $display("test reset done");
    wr(8'h80, 8'hA5);
    wr(8'h98, 8'h0F);
    `CHK("pad_oe", 8'h0F, pad_oe)
    `CHK("pad_out", 8'h05, pad_out & pad_oe)
    `CHK("gate_idle", 8'h00, pad_input_gate_en)
    rd(8'h80, 8'h35);
    `CHK("gate_read", 8'hFF, gate_snap)
    rd(8'hC3, 8'h35);
    @(posedge core_clk);
    sec_en <= 8'h01;
    #1 `CHK("gate_sec", 8'h01, pad_input_gate_en)
    `CHK("digital_in_sec", 8'h01, digital_in)
    $display("test direction done");
    wr(8'h89, 8'hF0);
    `CHK("pad_pullup_en", 8'hF0, pad_pullup_en)
    wr(8'hC0, 8'h5A);
    wr(8'hC1, 8'hA5);
    rd(8'hC0, 8'h5A);
    rd(8'hC1, 8'hA5);
    `CHK("pad_pullup_kept", 8'hF0, pad_pullup_en)
    $display("test pullup done");
    wr(8'hC2, 8'h01);
    `CHK("pad_oe_od", 8'h0E, pad_oe)
    rd(8'hC3, 8'h34);
    rd(8'h80, 8'h35);
    $display("test open drain done");
    @(posedge core_clk);
    ext_val <= 8'hFF;
    sec_en <= 8'hFF;
    wr(8'hC4, 8'hFF);
    rd(8'hC4, 8'hC0);
    `CHK("analog_path_en", 8'hC0, analog_path_en)
    `CHK("gate_analog", 8'h3F, pad_input_gate_en)
    rd(8'h80, 8'h35);
    `CHK("gate_analog_read", 8'h3F, gate_snap)
    `CHK("digital_in_analog", 8'h35, digital_in)
    $display("test analog done");
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h89, 8'h00);
    rd(8'h98, 8'h00);
    rd(8'h80, 8'hFF);
    `CHK("pad_oe_rst", 8'h00, pad_oe)
    `CHK("pad_pullup_en_rst", 8'h00, pad_pullup_en)
    $display("test mid reset done");
    test_done;
  end
endmodule
